// [logic/trig_pkg.sv]
// Constants and register map of the dual camera trigger generator
//
// Contract
// - Two separate trigger outputs exist: primary and secondary.
// - Each output has its own enable; a disabled output never pulses.
// - Primary repeats at a configurable rate between 6 Hz and 50 Hz.
// - Primary pulse high time is programmable, any duration in microseconds below the period.
// - Outputs are active high: rest low, high during a pulse.
// - Secondary runs only while primary is enabled; disabling primary stops it.
// - Secondary always repeats at exactly the primary frequency.
// - Secondary rising edge follows primary rising edge by a programmable offset.
// - Secondary has its own programmable pulse high time.
package trig_pkg;

    // Bus geometry
    localparam int DATA_W = 32;
    localparam int ADDR_W = 5;
    localparam int BE_W   = 4;
    localparam int BYTE_W = 8;

    // Timebase: one microsecond tick derived from the 250 MHz clock
    localparam int CLK_PERIOD_NS = 4;
    localparam int US_NS         = 1000;
    localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W        = 8;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(US_CYCLES - 1);

    // Phase, period, width and offset all count microsecond ticks
    localparam int PHASE_W     = 18;
    localparam int US_PER_S    = 1000000;
    localparam int FREQ_MIN_HZ = 6;
    localparam int FREQ_MAX_HZ = 50;
    localparam int FREQ_DEF_HZ = 30;
    localparam int WIDTH_DEF_US = 1000;
    localparam logic [PHASE_W-1:0] PERIOD_MIN_US = PHASE_W'(US_PER_S / FREQ_MAX_HZ);
    localparam logic [PHASE_W-1:0] PERIOD_MAX_US = PHASE_W'(US_PER_S / FREQ_MIN_HZ);
    localparam logic [PHASE_W-1:0] PERIOD_RST    = PHASE_W'(US_PER_S / FREQ_DEF_HZ);
    localparam logic [PHASE_W-1:0] WIDTH_RST     = PHASE_W'(WIDTH_DEF_US);
    localparam logic [PHASE_W-1:0] OFFSET_RST    = 18'h00000;
    localparam logic [PHASE_W-1:0] PHASE_ONE     = 18'h00001;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL   = 5'h00;
    localparam logic [ADDR_W-1:0] REG_PERIOD = 5'h04;
    localparam logic [ADDR_W-1:0] REG_WIDTH0 = 5'h08;
    localparam logic [ADDR_W-1:0] REG_OFFSET = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_WIDTH1 = 5'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h14;
    localparam logic [ADDR_W-1:0] REG_PHASE  = 5'h18;

    // Field positions
    localparam int CTRL_EN0_BIT   = 0;
    localparam int CTRL_EN1_BIT   = 1;
    localparam int STAT_OUT0_BIT  = 0;
    localparam int STAT_OUT1_BIT  = 1;
    localparam int STAT_RUN1_BIT  = 2;

    localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

endpackage

// [logic/us_tick_divider.sv]
// Divides the system clock into a one-cycle microsecond enable pulse
`timescale 1ns/1ps
`default_nettype none
module us_tick_divider (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic clear,
    output logic      tick
);
    typedef struct packed {
        logic [trig_pkg::TICK_W-1:0] count;
        logic                        tick;
    } div_state_t;

    div_state_t state_r;
    div_state_t state_nxt;

    // Count to the last cycle of a microsecond, then pulse and wrap
    always_comb begin
        state_nxt      = state_r;
        state_nxt.tick = 1'b0;
        if (clear) begin
            state_nxt.count = '0;
        end else if (state_r.count == trig_pkg::TICK_LAST) begin
            state_nxt.count = '0;
            state_nxt.tick  = 1'b1;
        end else begin
            state_nxt.count = state_r.count + 8'h01;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign tick = state_r.tick;
endmodule
`default_nettype wire

// [logic/pulse_window.sv]
// Decides whether a phase lies inside a pulse window that may wrap the period
`timescale 1ns/1ps
`default_nettype none
module pulse_window (
    input  wire logic [trig_pkg::PHASE_W-1:0] phase,
    input  wire logic [trig_pkg::PHASE_W-1:0] period,
    input  wire logic [trig_pkg::PHASE_W-1:0] start,
    input  wire logic [trig_pkg::PHASE_W-1:0] width,
    output logic                              hit
);
    logic [trig_pkg::PHASE_W-1:0] since;

    // Distance from the window start, taken modulo the period
    always_comb begin
        if (phase >= start) begin
            since = phase - start;
        end else begin
            since = phase + (period - start);
        end
        hit = (since < width);
    end
endmodule
`default_nettype wire

// [logic/dual_camera_trigger_gen.sv]
// Dual camera trigger generator with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module dual_camera_trigger_gen (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic [trig_pkg::ADDR_W-1:0]   avsAddress,
    input  wire logic                          avsRead,
    input  wire logic                          avsWrite,
    input  wire logic [trig_pkg::DATA_W-1:0]   avsWriteData,
    input  wire logic [trig_pkg::BE_W-1:0]     avsByteEnable,
    output logic      [trig_pkg::DATA_W-1:0]   avsReadData,
    output logic                               avsWaitRequest,
    output logic                               trigPrimary,
    output logic                               trigSecondary
);
    typedef struct packed {
        logic                          en0;
        logic                          en1;
        logic                          en0Prev;
        logic [trig_pkg::PHASE_W-1:0]  period;
        logic [trig_pkg::PHASE_W-1:0]  width0;
        logic [trig_pkg::PHASE_W-1:0]  offset;
        logic [trig_pkg::PHASE_W-1:0]  width1;
        logic [trig_pkg::PHASE_W-1:0]  phase;
        logic                          outP;
        logic                          outS;
        logic                          waitReq;
        logic [trig_pkg::DATA_W-1:0]   rdata;
    } gen_state_t;

    gen_state_t                    state_r;
    gen_state_t                    state_nxt;
    logic [trig_pkg::PHASE_W-1:0]  periodEff;
    logic [trig_pkg::PHASE_W-1:0]  width0Eff;
    logic [trig_pkg::PHASE_W-1:0]  offsetEff;
    logic [trig_pkg::PHASE_W-1:0]  width1Eff;
    logic                          restart;
    logic                          tickClear;
    logic                          usTick;
    logic                          hitPrimary;
    logic                          hitSecondary;
    logic [trig_pkg::DATA_W-1:0]   readMux;
    logic [trig_pkg::DATA_W-1:0]   wordOld;
    logic [trig_pkg::DATA_W-1:0]   wordNew;

    // Merge write data into an old word under the byte enables
    function automatic logic [trig_pkg::DATA_W-1:0] merge_bytes(
        input logic [trig_pkg::DATA_W-1:0] cur,
        input logic [trig_pkg::DATA_W-1:0] wd,
        input logic [trig_pkg::BE_W-1:0]   be
    );
        logic [trig_pkg::DATA_W-1:0] res;
        res = cur;
        for (int i = 0; i < trig_pkg::BE_W; i++) begin
            if (be[i]) begin
                res[i*trig_pkg::BYTE_W +: trig_pkg::BYTE_W] =
                    wd[i*trig_pkg::BYTE_W +: trig_pkg::BYTE_W];
            end
        end
        return res;
    endfunction

    // Clamp the period into the legal frequency range and settings below it
    always_comb begin
        if (state_r.period < trig_pkg::PERIOD_MIN_US) begin
            periodEff = trig_pkg::PERIOD_MIN_US;
        end else if (state_r.period > trig_pkg::PERIOD_MAX_US) begin
            periodEff = trig_pkg::PERIOD_MAX_US;
        end else begin
            periodEff = state_r.period;
        end
        width0Eff = (state_r.width0 >= periodEff) ? periodEff - trig_pkg::PHASE_ONE
                                                   : state_r.width0;
        offsetEff = (state_r.offset >= periodEff) ? periodEff - trig_pkg::PHASE_ONE
                                                   : state_r.offset;
        width1Eff = (state_r.width1 >= periodEff) ? periodEff - trig_pkg::PHASE_ONE
                                                   : state_r.width1;
    end

    // Restart the timebase on the enabling edge and while idle
    assign restart   = state_r.en0 && !state_r.en0Prev;
    assign tickClear = restart || !state_r.en0;

    us_tick_divider tickGen (
        .clk   (clk),
        .rst   (rst),
        .clear (tickClear),
        .tick  (usTick)
    );

    // Primary window opens at phase zero
    pulse_window primaryWin (
        .phase  (state_r.phase),
        .period (periodEff),
        .start  ({trig_pkg::PHASE_W{1'b0}}),
        .width  (width0Eff),
        .hit    (hitPrimary)
    );

    // Secondary window shares the period and opens at the offset
    pulse_window secondaryWin (
        .phase  (state_r.phase),
        .period (periodEff),
        .start  (offsetEff),
        .width  (width1Eff),
        .hit    (hitSecondary)
    );

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        readMux = trig_pkg::READ_ZERO;
        case (avsAddress)
            trig_pkg::REG_CTRL: begin
                readMux[trig_pkg::CTRL_EN0_BIT] = state_r.en0;
                readMux[trig_pkg::CTRL_EN1_BIT] = state_r.en1;
            end
            trig_pkg::REG_PERIOD: readMux[trig_pkg::PHASE_W-1:0] = state_r.period;
            trig_pkg::REG_WIDTH0: readMux[trig_pkg::PHASE_W-1:0] = state_r.width0;
            trig_pkg::REG_OFFSET: readMux[trig_pkg::PHASE_W-1:0] = state_r.offset;
            trig_pkg::REG_WIDTH1: readMux[trig_pkg::PHASE_W-1:0] = state_r.width1;
            trig_pkg::REG_STATUS: begin
                readMux[trig_pkg::STAT_OUT0_BIT] = state_r.outP;
                readMux[trig_pkg::STAT_OUT1_BIT] = state_r.outS;
                readMux[trig_pkg::STAT_RUN1_BIT] = state_r.en0 && state_r.en1;
            end
            trig_pkg::REG_PHASE:  readMux[trig_pkg::PHASE_W-1:0] = state_r.phase;
            default:              readMux = trig_pkg::READ_ZERO;
        endcase
    end

    // Old contents of the addressed word, for byte-lane merging
    assign wordOld = readMux;
    assign wordNew = merge_bytes(wordOld, avsWriteData, avsByteEnable);

    // Next state: bus handshake, register writes, phase counter, outputs
    always_comb begin
        state_nxt         = state_r;
        state_nxt.en0Prev = state_r.en0;
        state_nxt.waitReq = 1'b1;

        // Hold waitrequest high one cycle, then release it for one cycle
        if ((avsRead || avsWrite) && state_r.waitReq) begin
            state_nxt.waitReq = 1'b0;
            if (avsRead) begin
                state_nxt.rdata = readMux;
            end
        end

        // Writes take effect at the edge where waitrequest is sampled low
        if (avsWrite && !state_r.waitReq) begin
            case (avsAddress)
                trig_pkg::REG_CTRL: begin
                    state_nxt.en0 = wordNew[trig_pkg::CTRL_EN0_BIT];
                    state_nxt.en1 = wordNew[trig_pkg::CTRL_EN1_BIT];
                end
                trig_pkg::REG_PERIOD: state_nxt.period = wordNew[trig_pkg::PHASE_W-1:0];
                trig_pkg::REG_WIDTH0: state_nxt.width0 = wordNew[trig_pkg::PHASE_W-1:0];
                trig_pkg::REG_OFFSET: state_nxt.offset = wordNew[trig_pkg::PHASE_W-1:0];
                trig_pkg::REG_WIDTH1: state_nxt.width1 = wordNew[trig_pkg::PHASE_W-1:0];
                default: begin
                end
            endcase
        end

        // Secondary cannot stay enabled without the primary
        state_nxt.en1 = state_nxt.en1 && state_nxt.en0;

        // Phase counts microseconds and wraps at the effective period
        if (!state_r.en0 || restart) begin
            state_nxt.phase = '0;
        end else if (state_r.phase >= periodEff) begin
            state_nxt.phase = '0;
        end else if (usTick) begin
            if (state_r.phase == periodEff - trig_pkg::PHASE_ONE) begin
                state_nxt.phase = '0;
            end else begin
                state_nxt.phase = state_r.phase + trig_pkg::PHASE_ONE;
            end
        end

        // Active-high outputs gated by their enables
        state_nxt.outP = state_r.en0 && hitPrimary;
        state_nxt.outS = state_r.en0 && state_r.en1 && hitSecondary;
    end

    // State register with defaults after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r         <= '0;
            state_r.period  <= trig_pkg::PERIOD_RST;
            state_r.width0  <= trig_pkg::WIDTH_RST;
            state_r.width1  <= trig_pkg::WIDTH_RST;
            state_r.offset  <= trig_pkg::OFFSET_RST;
            state_r.waitReq <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from the state register
    assign avsReadData    = state_r.rdata;
    assign avsWaitRequest = state_r.waitReq;
    assign trigPrimary    = state_r.outP;
    assign trigSecondary  = state_r.outS;

    // Helper history for the offset check
    logic                          prevBothEn;
    logic [trig_pkg::PHASE_W-1:0]  prevPhase;
    logic [trig_pkg::PHASE_W-1:0]  prevOffset;
    logic [trig_pkg::PHASE_W-1:0]  prevWidth1;
    logic [trig_pkg::PHASE_W-1:0]  prevWidth1b;
    always_ff @(posedge clk) begin
        prevBothEn  <= state_r.en0 && state_r.en1 && state_r.en0Prev;
        prevPhase   <= state_r.phase;
        prevOffset  <= offsetEff;
        prevWidth1  <= width1Eff;
        prevWidth1b <= prevWidth1;
    end

    // Disabled primary drives low on the next edge
    prim_idle_low_a: assert property (@(posedge clk) disable iff (rst)
        !state_r.en0 |=> !trigPrimary)
        else $error("primary pulsed while disabled");

    // Secondary needs the primary enabled one cycle before
    sec_needs_prim_a: assert property (@(posedge clk) disable iff (rst)
        trigSecondary |-> $past(state_r.en0) && $past(state_r.en1))
        else $error("secondary pulsed without both enables");

    // Outputs low right after reset
    reset_low_a: assert property (@(posedge clk) disable iff (rst)
        $past(rst) |-> !trigPrimary && !trigSecondary)
        else $error("trigger high after reset");

    // Enabling the primary starts with a pulse
    restart_pulse_a: assert property (@(posedge clk) disable iff (rst)
        (restart && width0Eff != '0) |=> trigPrimary ##1 (state_r.phase == '0))
        else $error("enable did not start with a pulse");

    // Phase wraps to zero at the end of the period
    phase_wrap_a: assert property (@(posedge clk) disable iff (rst)
        (state_r.en0 && !restart && usTick
         && state_r.phase == periodEff - trig_pkg::PHASE_ONE) |=> state_r.phase == '0)
        else $error("phase did not wrap at period end");

    // Effective settings stay inside the legal range
    clamp_range_a: assert property (@(posedge clk) disable iff (rst)
        periodEff >= trig_pkg::PERIOD_MIN_US && periodEff <= trig_pkg::PERIOD_MAX_US
        && width0Eff < periodEff && width1Eff < periodEff && offsetEff < periodEff)
        else $error("effective setting out of range");

    // Primary high exactly while phase lies below its width
    prim_width_a: assert property (@(posedge clk) disable iff (rst)
        state_r.en0 |=> trigPrimary == ($past(state_r.phase) < $past(width0Eff)))
        else $error("primary level disagrees with phase");

    // Secondary rises when the phase reaches the offset
    sec_offset_a: assert property (@(posedge clk) disable iff (rst)
        ($rose(trigSecondary) && prevBothEn && prevWidth1 == prevWidth1b)
        |-> prevPhase == prevOffset)
        else $error("secondary rose away from its offset");

    // Waitrequest is released for a single cycle only
    bus_release_a: assert property (@(posedge clk) disable iff (rst)
        !avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low for more than one cycle");

    // A request seen with waitrequest high is answered in the next cycle
    bus_answer_a: assert property (@(posedge clk) disable iff (rst)
        (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
        else $error("waitrequest not released one cycle after a request");

    // Secondary drives low once its own enable is clear
    sec_idle_low_a: assert property (@(posedge clk) disable iff (rst)
        !state_r.en1 |=> !trigSecondary)
        else $error("secondary pulsed while disabled");

    // A control write that clears the primary enable also clears the secondary
    en1_follow_a: assert property (@(posedge clk) disable iff (rst)
        (avsWrite && !avsWaitRequest && avsAddress == trig_pkg::REG_CTRL
         && avsByteEnable[trig_pkg::CTRL_EN0_BIT / trig_pkg::BYTE_W]
         && !avsWriteData[trig_pkg::CTRL_EN0_BIT]) |=> !state_r.en1)
        else $error("secondary enable kept without primary");

    // A full-word offset write lands at the commit edge
    write_offset_a: assert property (@(posedge clk) disable iff (rst)
        (avsWrite && !avsWaitRequest && avsAddress == trig_pkg::REG_OFFSET
         && &avsByteEnable) |=> state_r.offset == $past(avsWriteData[trig_pkg::PHASE_W-1:0]))
        else $error("offset write did not land");

    // A full-word secondary width write lands at the commit edge
    write_width1_a: assert property (@(posedge clk) disable iff (rst)
        (avsWrite && !avsWaitRequest && avsAddress == trig_pkg::REG_WIDTH1
         && &avsByteEnable) |=> state_r.width1 == $past(avsWriteData[trig_pkg::PHASE_W-1:0]))
        else $error("secondary width write did not land");

    // Status read returns the levels of both trigger outputs
    status_read_a: assert property (@(posedge clk) disable iff (rst)
        (avsRead && avsWaitRequest && avsAddress == trig_pkg::REG_STATUS)
        |=> avsReadData[trig_pkg::STAT_OUT0_BIT] == $past(trigPrimary)
            && avsReadData[trig_pkg::STAT_OUT1_BIT] == $past(trigSecondary))
        else $error("status read disagrees with trigger levels");

    prim_rise_c: cover property (@(posedge clk) disable iff (rst) $rose(trigPrimary));
    sec_rise_c: cover property (@(posedge clk) disable iff (rst) $rose(trigSecondary));
    bus_write_c: cover property (@(posedge clk) disable iff (rst)
        avsWrite && !avsWaitRequest);
    restart_c: cover property (@(posedge clk) disable iff (rst) restart);
    both_high_c: cover property (@(posedge clk) disable iff (rst) trigPrimary && trigSecondary);
endmodule
`default_nettype wire

// [test/camera_trigger_input.sv]
// Behavioural model of one camera trigger input that logs pulse timing
`timescale 1ns/1ps
`default_nettype none
module camera_trigger_input (
    input  wire logic clk,
    input  wire logic trig,
    output var  int   rises,
    output var  int   riseAt,
    output var  int   highLen
);
    int   now = 0;
    int   startAt = 0;
    int   riseCount = 0;
    int   lastRise = 0;
    int   lastLen = 0;
    logic prev = 1'b0;

    // Camera set to external trigger, active high: a pulse starts on a low to high step
    always @(posedge clk) begin
        now = now + 1;
        if (trig === 1'b1 && prev === 1'b0) begin
            riseCount = riseCount + 1;
            lastRise = now;
            startAt = now;
        end
        if (trig !== 1'b1 && prev === 1'b1) begin
            lastLen = now - startAt;
        end
        prev = trig;
    end

    // Logged figures, each with a single driver
    assign rises   = riseCount;
    assign riseAt  = lastRise;
    assign highLen = lastLen;
endmodule
`default_nettype wire

// [test/dual_camera_trigger_generator_bench.sv]
// Self-checking bench for the dual camera trigger generator
`timescale 1ns/1ps
`default_nettype none
module dual_camera_trigger_generator_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  avsAddress = 5'h00;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h00000000;
    logic [3:0]  avsByteEnable = 4'hF;
    logic [31:0] avsReadData;
    logic        avsWaitRequest;
    logic        trigPrimary;
    logic        trigSecondary;
    int          priRises, priAt, priLen, secRises, secAt, secLen;
    int          fails = 0;
    int          numChecks = 0;
    int          p0, s0;

    dual_camera_trigger_gen dual_camera_trigger_gen_inst (.clk(clk), .rst(rst),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .trigPrimary(trigPrimary), .trigSecondary(trigSecondary));
    camera_trigger_input primary_cam_inst (.clk(clk), .trig(trigPrimary),
        .rises(priRises), .riseAt(priAt), .highLen(priLen));
    camera_trigger_input secondary_cam_inst (.clk(clk), .trig(trigSecondary),
        .rises(secRises), .riseAt(secAt), .highLen(secLen));

    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        numChecks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Timing figures may sit a couple of cycles off the ideal edge
    task automatic near(input int got, input int exp, input string what);
        numChecks++;
        if (got < exp - 2 || got > exp + 2) begin
            fails++;
            $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low, bounded
    task automatic waitGrant();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 20);
        if (avsWaitRequest !== 1'b0) begin
            fails++;
            $display("mismatch at %0t: bus answer timed out", $time);
            report_and_stop();
        end
    endtask

    task automatic busWrite(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avsAddress <= a;
        avsWriteData <= d;
        avsByteEnable <= be;
        avsWrite <= 1'b1;
        waitGrant();
        avsWrite <= 1'b0;
    endtask

    task automatic readChk(input logic [4:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        avsAddress <= a;
        avsRead <= 1'b1;
        waitGrant();
        chk(avsReadData, exp, what);
        avsRead <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    initial begin
        idle(2);
        rst <= 1'b0;
        idle(1);
        chk({trigPrimary, trigSecondary}, 32'h0, "idle outputs");
        readChk(5'h00, 32'h0, "ctrl reset");
        readChk(5'h04, 32'(trig_pkg::PERIOD_RST), "period reset");
        readChk(5'h08, 32'(trig_pkg::WIDTH_RST), "width0 reset");
        readChk(5'h0C, 32'(trig_pkg::OFFSET_RST), "offset reset");
        readChk(5'h10, 32'(trig_pkg::WIDTH_RST), "width1 reset");
        busWrite(5'h1C, 32'hFFFFFFFF, 4'hF);
        readChk(5'h1C, 32'h0, "unmapped");
        busWrite(5'h08, 32'hFFFFFF04, 4'h1);
        readChk(5'h08, 32'h00000304, "byte lane");
        $display("test registers done");

        // Secondary alone is refused
        busWrite(5'h00, 32'h2, 4'hF);
        readChk(5'h00, 32'h0, "ctrl en1 alone");
        idle(1000);
        chk(secRises, 32'h0, "secondary alone pulses");
        $display("test secondary refused done");

        // Primary only: 4 us pulse, secondary silent
        busWrite(5'h08, 32'h4, 4'hF);
        busWrite(5'h0C, 32'h8, 4'hF);
        busWrite(5'h10, 32'h6, 4'hF);
        p0 = priRises;
        busWrite(5'h00, 32'h1, 4'hF);
        idle(300);
        readChk(5'h14, 32'h1, "status primary high");
        readChk(5'h18, 32'h1, "phase after first tick");
        idle(4000);
        chk(priRises - p0, 32'h1, "primary pulse count");
        near(priLen, 1000, "primary width");
        chk(secRises, 32'h0, "secondary disabled");
        $display("test primary done");

        // Both outputs: offset 8 us, own width 6 us
        busWrite(5'h00, 32'h0, 4'hF);
        p0 = priRises;
        s0 = secRises;
        busWrite(5'h00, 32'h3, 4'hF);
        idle(2400);
        readChk(5'h14, 32'h6, "status secondary high");
        idle(2000);
        chk(priRises - p0, 32'h1, "primary again");
        chk(secRises - s0, 32'h1, "secondary pulse count");
        near(secAt - priAt, 2000, "secondary offset");
        near(secLen, 1500, "secondary width");
        near(priLen, 1000, "primary width again");
        $display("test secondary done");

        // Mid-pulse: clearing en1 stops the secondary, then disabling primary stops both
        busWrite(5'h0C, 32'h1, 4'hF);
        busWrite(5'h08, 32'h14, 4'hF);
        busWrite(5'h00, 32'h0, 4'hF);
        busWrite(5'h00, 32'h3, 4'hF);
        idle(600);
        chk({trigPrimary, trigSecondary}, 32'h3, "both high");
        busWrite(5'h00, 32'h1, 4'hF);
        idle(2);
        chk(trigSecondary, 1'b0, "secondary disabled alone");
        busWrite(5'h00, 32'h0, 4'hF);
        idle(2);
        chk({trigPrimary, trigSecondary}, 32'h0, "dropped on disable");
        readChk(5'h00, 32'h0, "ctrl after disable");
        $display("test disable done");

        // Reset in mid-pulse
        busWrite(5'h00, 32'h3, 4'hF);
        idle(700);
        rst <= 1'b1;
        idle(2);
        chk({trigPrimary, trigSecondary}, 32'h0, "outputs in reset");
        rst <= 1'b0;
        idle(1);
        readChk(5'h00, 32'h0, "ctrl after reset");
        $display("test reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
